// [rtl/sdcs_pkg.sv]
package sdcs_pkg;

    // register map, byte addresses
    localparam logic [31:0] SDCS_CFG_ADDR = 32'h3108_0100;
    localparam logic [31:0] SDCS_LAT_ADDR = 32'h3108_0104;

    // chip_select0_config fields
    localparam int SDCS_WP_BIT = 20;
    localparam int SDCS_AM_LSB = 7;
    localparam int SDCS_AM_W   = 8;
    localparam int SDCS_MD_LSB = 0;
    localparam int SDCS_MD_W   = 3;

    // chip_select0_latency fields
    localparam int SDCS_CAS_LSB = 7;
    localparam int SDCS_RAS_LSB = 0;
    localparam int SDCS_LAT_W   = 4;

    // reset values
    localparam logic                  SDCS_WP_RST  = 1'b0;
    localparam logic [SDCS_AM_W-1:0]  SDCS_AM_RST  = 8'h00;
    localparam logic [SDCS_MD_W-1:0]  SDCS_MD_RST  = 3'h0;
    localparam logic [SDCS_LAT_W-1:0] SDCS_CAS_RST = 4'h6;
    localparam logic [SDCS_LAT_W-1:0] SDCS_RAS_RST = 4'h3;

    // memory type codes
    localparam logic [2:0] SDCS_MD_SDR   = 3'h0;
    localparam logic [2:0] SDCS_MD_LPSDR = 3'h2;
    localparam logic [2:0] SDCS_MD_DDR   = 3'h4;
    localparam logic [2:0] SDCS_MD_LPDDR = 3'h6;

    // address-mapping sub-fields (within the 8-bit field)
    localparam int         SDCS_AM_BUS_BIT = 7;
    localparam logic [1:0] SDCS_ORD_HP     = 2'h0;
    localparam logic [1:0] SDCS_ORD_LP     = 2'h1;
    localparam logic [1:0] SDCS_DW_X8      = 2'h0;
    localparam logic [1:0] SDCS_DW_X16     = 2'h1;
    localparam logic [1:0] SDCS_DW_X32     = 2'h2;
    localparam logic [2:0] SDCS_DEN_MAX    = 3'h4;
    localparam logic [3:0] SDCS_X32_COL    = 4'h8;

    // translated command widths
    localparam int SDCS_ROW_W  = 13;
    localparam int SDCS_COL_W  = 11;
    localparam int SDCS_BANK_W = 2;

    typedef struct packed {
        logic       ok;
        logic       bus32;
        logic       low_pow;
        logic       bank4;
        logic [3:0] row_len;
        logic [3:0] col_len;
    } sdcs_geo_s;

    typedef struct packed {
        logic                   vld;
        logic                   wr;
        logic [SDCS_BANK_W-1:0] bank;
        logic [SDCS_ROW_W-1:0]  row;
        logic [SDCS_COL_W-1:0]  col;
    } sdcs_cmd_s;

    typedef struct packed {
        logic        vld;
        logic [31:0] addr;
        logic [31:0] data;
    } sdcs_wr_s;

    typedef struct packed {
        sdcs_wr_s                pend;
        logic                    wp;
        logic [SDCS_AM_W-1:0]    am;
        logic [SDCS_MD_W-1:0]    md;
        logic                    md_ok;
        logic [SDCS_LAT_W-1:0]   cas;
        logic [SDCS_LAT_W-1:0]   ras;
        logic                    lat_ok;
        logic [31:0]             rdata;
        sdcs_cmd_s               cmd;
        logic                    wp_blk;
        sdcs_geo_s               geo;
    } sdcs_st_s;

    function automatic logic [31:0] sdcs_mask(input logic [3:0] n);
        return (32'h1 << n) - 32'h1;
    endfunction

endpackage

// [rtl/sdcs_map_decode.sv]
`timescale 1ns/1ps
module sdcs_map_decode
    import sdcs_pkg::*;
(
    input  wire logic [SDCS_AM_W-1:0] am_i,  // address-mapping field
    output sdcs_geo_s                 geo_o  // decoded geometry
);
    logic [1:0] ord;
    logic [2:0] den;
    logic [1:0] dw;
    logic [3:0] col8;

    always_comb begin
        ord  = am_i[6:5];
        den  = am_i[4:2];
        dw   = am_i[1:0];
        geo_o = '0;
        geo_o.bus32   = am_i[SDCS_AM_BUS_BIT];
        geo_o.low_pow = (ord == SDCS_ORD_LP);
        geo_o.bank4   = (den != 3'h0);
        unique case (den)
            3'h0:    geo_o.row_len = 4'd11;
            3'h1, 3'h2: geo_o.row_len = 4'd12;
            default: geo_o.row_len = 4'd13;
        endcase
        unique case (den)
            3'h0, 3'h1: col8 = 4'd9;
            3'h2, 3'h3: col8 = 4'd10;
            default:    col8 = 4'd11;
        endcase
        unique case (dw)
            SDCS_DW_X8:  geo_o.col_len = col8;
            SDCS_DW_X16: geo_o.col_len = col8 - 4'd1;
            default:     geo_o.col_len = SDCS_X32_COL;
        endcase
        if (dw == SDCS_DW_X32 && den == 3'h1) begin
            geo_o.row_len = 4'd11;
        end
        // listed codes only; x32 only on 32-bit maps, density 1..3
        geo_o.ok = (ord == SDCS_ORD_HP || ord == SDCS_ORD_LP)
                && (den <= SDCS_DEN_MAX)
                && (dw == SDCS_DW_X8 || dw == SDCS_DW_X16
                    || (dw == SDCS_DW_X32 && am_i[SDCS_AM_BUS_BIT]
                        && den != 3'h0 && den != SDCS_DEN_MAX));
    end
endmodule

// [rtl/sdcs_addr_xlate.sv]
`timescale 1ns/1ps
module sdcs_addr_xlate
    import sdcs_pkg::*;
(
    input  sdcs_geo_s                    geo_i,   // decoded geometry
    input  wire logic [31:0]             addr_i,  // system byte address
    output logic [SDCS_BANK_W-1:0]       bank_o,  // bank index
    output logic [SDCS_ROW_W-1:0]        row_o,   // row index
    output logic [SDCS_COL_W-1:0]        col_o    // column index
);
    logic [31:0] w;
    logic [31:0] t;
    logic [3:0]  bb;

    always_comb begin
        // drop the byte lanes of one bus beat
        w  = geo_i.bus32 ? (addr_i >> 2) : (addr_i >> 1);
        bb = geo_i.bank4 ? 4'd2 : 4'd1;
        col_o = SDCS_COL_W'(w & sdcs_mask(geo_i.col_len));
        t  = w >> geo_i.col_len;
        if (geo_i.low_pow) begin
            // bank on top keeps whole banks idle for partial arrays
            row_o  = SDCS_ROW_W'(t & sdcs_mask(geo_i.row_len));
            bank_o = SDCS_BANK_W'((t >> geo_i.row_len)
                     & sdcs_mask(bb));
        end else begin
            bank_o = SDCS_BANK_W'(t & sdcs_mask(bb));
            row_o  = SDCS_ROW_W'((t >> bb)
                     & sdcs_mask(geo_i.row_len));
        end
    end
endmodule

// [rtl/sdcs_top.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module sdcs_top
    import sdcs_pkg::*;
(
    input  wire logic                  sys_clk_i,   // 250 MHz clock
    input  wire logic                  rst_n_i,     // async reset, low
    input  wire logic [31:0]           reg_addr_i,  // register address
    input  wire logic [31:0]           reg_wdata_i, // register write data
    input  wire logic                  reg_wr_i,    // write strobe
    input  wire logic                  reg_rd_i,    // read strobe
    output logic [31:0]                reg_rdata_o, // read data, +1 cycle
    input  wire logic                  req_vld_i,   // memory request
    input  wire logic                  req_wr_i,    // request is a write
    input  wire logic [31:0]           req_addr_i,  // system byte address
    output sdcs_cmd_s                  cmd_o,       // translated request
    output logic                       wp_block_o,  // write refused pulse
    output sdcs_geo_s                  geo_o,       // decoded geometry
    output logic                       wp_o,        // write protect level
    output logic [SDCS_MD_W-1:0]       md_o,        // memory type
    output logic                       md_ok_o,     // type code legal
    output logic [SDCS_LAT_W-1:0]      cas_half_o,  // CAS in half cycles
    output logic [SDCS_LAT_W-1:0]      ras_cyc_o,   // RAS in cycles
    output logic                       lat_ok_o     // latency codes legal
);

    sdcs_st_s st_q;
    sdcs_st_s st_d;

    sdcs_geo_s                geo_c;
    logic [SDCS_BANK_W-1:0]   x_bank;
    logic [SDCS_ROW_W-1:0]    x_row;
    logic [SDCS_COL_W-1:0]    x_col;

    // effective register values once the pending write lands
    logic                     e_wp;
    logic [SDCS_AM_W-1:0]     e_am;
    logic [SDCS_MD_W-1:0]     e_md;
    logic [SDCS_LAT_W-1:0]    e_cas;
    logic [SDCS_LAT_W-1:0]    e_ras;

    sdcs_map_decode u_dec (
        .am_i  (st_q.am),
        .geo_o (geo_c)
    );

    sdcs_addr_xlate u_xlt (
        .geo_i  (geo_c),
        .addr_i (req_addr_i),
        .bank_o (x_bank),
        .row_o  (x_row),
        .col_o  (x_col)
    );

    always_comb begin
        e_wp  = st_q.wp;
        e_am  = st_q.am;
        e_md  = st_q.md;
        e_cas = st_q.cas;
        e_ras = st_q.ras;
        // the write lands one cycle after its strobe
        if (st_q.pend.vld && st_q.pend.addr == SDCS_CFG_ADDR) begin
            e_wp = st_q.pend.data[SDCS_WP_BIT];
            e_am = st_q.pend.data[SDCS_AM_LSB +: SDCS_AM_W];
            e_md = st_q.pend.data[SDCS_MD_LSB +: SDCS_MD_W];
        end
        if (st_q.pend.vld && st_q.pend.addr == SDCS_LAT_ADDR) begin
            e_cas = st_q.pend.data[SDCS_CAS_LSB +: SDCS_LAT_W];
            e_ras = st_q.pend.data[SDCS_RAS_LSB +: SDCS_LAT_W];
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.wp  = e_wp;
        st_d.am  = e_am;
        st_d.md  = e_md;
        st_d.cas = e_cas;
        st_d.ras = e_ras;
        st_d.md_ok  = (e_md[0] == 1'b0);
        st_d.lat_ok = (e_cas != 4'h0) && (e_ras != 4'h0);

        st_d.pend.vld  = reg_wr_i;
        st_d.pend.addr = reg_addr_i;
        st_d.pend.data = reg_wdata_i;

        // reserved bits read as zero; reads see a write already taken
        st_d.rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                SDCS_CFG_ADDR: begin
                    st_d.rdata[SDCS_WP_BIT]                 = e_wp;
                    st_d.rdata[SDCS_AM_LSB +: SDCS_AM_W]    = e_am;
                    st_d.rdata[SDCS_MD_LSB +: SDCS_MD_W]    = e_md;
                end
                SDCS_LAT_ADDR: begin
                    st_d.rdata[SDCS_CAS_LSB +: SDCS_LAT_W]  = e_cas;
                    st_d.rdata[SDCS_RAS_LSB +: SDCS_LAT_W]  = e_ras;
                end
                default: st_d.rdata = '0;
            endcase
        end

        // geometry comes from the mapping code only
        st_d.geo = geo_c;

        st_d.cmd    = '0;
        st_d.wp_blk = 1'b0;
        if (req_vld_i) begin
            if (req_wr_i && st_q.wp) begin
                st_d.wp_blk = 1'b1;
            end else begin
                st_d.cmd.vld  = 1'b1;
                st_d.cmd.wr   = req_wr_i;
                st_d.cmd.bank = x_bank;
                st_d.cmd.row  = x_row;
                st_d.cmd.col  = x_col;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q        <= '0;
            st_q.wp     <= SDCS_WP_RST;
            st_q.am     <= SDCS_AM_RST;
            st_q.md     <= SDCS_MD_RST;
            st_q.md_ok  <= 1'b1;
            st_q.cas    <= SDCS_CAS_RST;
            st_q.ras    <= SDCS_RAS_RST;
            st_q.lat_ok <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o = st_q.rdata;
    assign cmd_o       = st_q.cmd;
    assign wp_block_o  = st_q.wp_blk;
    assign geo_o       = st_q.geo;
    assign wp_o        = st_q.wp;
    assign md_o        = st_q.md;
    assign md_ok_o     = st_q.md_ok;
    assign cas_half_o  = st_q.cas;
    assign ras_cyc_o   = st_q.ras;
    assign lat_ok_o    = st_q.lat_ok;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    wp_block_a: assert property (
        req_vld_i && req_wr_i && wp_o |=> !cmd_o.vld && wp_block_o)
        else $error("protected write was not blocked");

    wr_pass_a: assert property (
        req_vld_i && !(req_wr_i && wp_o)
        |=> cmd_o.vld && !wp_block_o && cmd_o.wr == $past(req_wr_i))
        else $error("allowed request was not issued");

    md_legal_a: assert property (
        md_ok_o == (md_o == SDCS_MD_SDR || md_o == SDCS_MD_LPSDR
                    || md_o == SDCS_MD_DDR || md_o == SDCS_MD_LPDDR))
        else $error("memory type legality flag wrong");

    cfg_wait_a: assert property (
        (reg_wr_i && reg_addr_i == SDCS_CFG_ADDR ##1 !reg_wr_i)
        |=> st_q.am == $past(reg_wdata_i[14:7], 2)
            && wp_o == $past(reg_wdata_i[20], 2))
        else $error("config write did not land after one wait");

    geo_bus_a: assert property (
        geo_o.ok |-> geo_o.bus32 == $past(st_q.am[7])
                  && geo_o.low_pow == ($past(st_q.am[6:5]) == 2'h1))
        else $error("bus width or ordering decode wrong");

    x32_col_a: assert property (
        geo_o.ok && $past(st_q.am[1:0]) == 2'h2
        |-> geo_o.bus32 && geo_o.col_len == 4'd8)
        else $error("x32 map not on 32-bit bus with 8 columns");

    bank_cnt_a: assert property (
        geo_o.ok |-> geo_o.bank4 == ($past(st_q.am[4:2]) != 3'h0)
                  && geo_o.row_len >= 4'd11 && geo_o.row_len <= 4'd13)
        else $error("bank count or row length decode wrong");

    lat_legal_a: assert property (
        lat_ok_o == (cas_half_o != 4'h0 && ras_cyc_o != 4'h0))
        else $error("latency legality flag wrong");

    lat_read_a: assert property (
        reg_rd_i && reg_addr_i == SDCS_LAT_ADDR
        |=> reg_rdata_o[3:0] == ras_cyc_o
            && reg_rdata_o[10:7] == cas_half_o
            && reg_rdata_o[31:11] == 21'h0)
        else $error("latency read data wrong");

    map_order_a: assert property (
        req_vld_i && !req_wr_i && geo_c.ok && !geo_c.low_pow
        && !geo_c.bus32 && geo_c.col_len == 4'd9 && geo_c.bank4
        |=> cmd_o.col == $past(req_addr_i[9:1])
            && cmd_o.bank == $past(req_addr_i[11:10]))
        else $error("row-bank-column order wrong");

    // request path: exactly one answer per request, and none without one
    cmd_idle_a: assert property (
        !req_vld_i |=> !cmd_o.vld && !wp_block_o)
        else $error("command or block pulse without a request");

    one_answer_a: assert property (
        !(cmd_o.vld && wp_block_o))
        else $error("request both issued and blocked");

    cmd_clear_a: assert property (
        !cmd_o.vld |-> cmd_o.wr == 1'b0 && cmd_o.bank == '0
                    && cmd_o.row == '0 && cmd_o.col == '0)
        else $error("command fields not cleared between requests");

    lp_order_a: assert property (
        req_vld_i && !req_wr_i && geo_c.ok && geo_c.low_pow
        && !geo_c.bus32 && geo_c.col_len == 4'd11 && geo_c.bank4
        && geo_c.row_len == 4'd13
        |=> cmd_o.col == $past(req_addr_i[11:1])
            && cmd_o.row == $past(req_addr_i[24:12])
            && cmd_o.bank == $past(req_addr_i[26:25]))
        else $error("bank-row-column order wrong");

    hp_row_a: assert property (
        req_vld_i && !req_wr_i && geo_c.ok && !geo_c.low_pow
        && !geo_c.bus32 && geo_c.col_len == 4'd9 && geo_c.bank4
        && geo_c.row_len == 4'd13
        |=> cmd_o.row == $past(req_addr_i[24:12]))
        else $error("row above bank in wrong place");

    wide_col_a: assert property (
        req_vld_i && !req_wr_i && geo_c.ok && geo_c.bus32
        && geo_c.col_len == 4'd8
        |=> cmd_o.col == $past(req_addr_i[9:2]))
        else $error("32-bit bus column wrong");

    // geometry decode: only listed codes are marked valid
    two_bank_a: assert property (
        geo_o.ok && !geo_o.bank4 |-> geo_o.row_len == 4'd11)
        else $error("two-bank part without 11 row bits");

    col_range_a: assert property (
        geo_o.ok |-> geo_o.col_len >= 4'd8 && geo_o.col_len <= 4'd11)
        else $error("column length out of range");

    map_listed_a: assert property (
        geo_o.ok |-> $past(st_q.am[6:5]) <= 2'h1
                  && $past(st_q.am[4:2]) <= 3'h4)
        else $error("reserved mapping marked valid");

    // register path: values move only two edges after a write strobe
    cfg_hold_a: assert property (
        !$past(reg_wr_i, 2)
        |-> $stable(wp_o) && $stable(md_o) && $stable(st_q.am))
        else $error("config changed without a write");

    lat_hold_a: assert property (
        !$past(reg_wr_i, 2) |-> $stable(cas_half_o) && $stable(ras_cyc_o))
        else $error("latency changed without a write");

    lat_land_a: assert property (
        (reg_wr_i && reg_addr_i == SDCS_LAT_ADDR ##1 !reg_wr_i)
        |=> cas_half_o == $past(reg_wdata_i[10:7], 2)
            && ras_cyc_o == $past(reg_wdata_i[3:0], 2))
        else $error("latency write did not land after one wait");

    cfg_read_a: assert property (
        reg_rd_i && reg_addr_i == SDCS_CFG_ADDR
        |=> reg_rdata_o[20] == wp_o
            && reg_rdata_o[14:7] == st_q.am
            && reg_rdata_o[2:0] == md_o
            && reg_rdata_o[31:21] == 11'h0
            && reg_rdata_o[19:15] == 5'h0
            && reg_rdata_o[6:3] == 4'h0)
        else $error("config read data wrong");

    rd_quiet_a: assert property (
        !reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");

endmodule

// [bench/sdcs_sdram_model.sv]
`timescale 1ns/1ps
module sdcs_sdram_model
    import sdcs_pkg::*;
(
    input  wire logic   sys_clk_i, // controller clock
    input  wire logic   rst_n_i,   // async reset, low
    input  sdcs_cmd_s   cmd_i,     // translated request
    output logic [15:0] wr_seen_o, // writes reaching the memory
    output logic [15:0] rd_seen_o  // reads reaching the memory
);
    // counts only what the memory really receives, so a write that the
    // controller refused can be told apart from one that got through
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_seen_o <= 16'h0000;
            rd_seen_o <= 16'h0000;
        end else if (cmd_i.vld && cmd_i.wr) begin
            wr_seen_o <= wr_seen_o + 16'h0001;
        end else if (cmd_i.vld) begin
            rd_seen_o <= rd_seen_o + 16'h0001;
        end
    end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import sdcs_pkg::*;

    logic        sys_clk_i   = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [31:0] reg_addr_i  = 32'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        req_vld_i   = 1'b0;
    logic        req_wr_i    = 1'b0;
    logic [31:0] req_addr_i  = 32'h0;
    logic [31:0] reg_rdata_o;
    sdcs_cmd_s   cmd_o;
    sdcs_geo_s   geo_o;
    logic        wp_block_o;
    logic        wp_o;
    logic [2:0]  md_o;
    logic        md_ok_o;
    logic [3:0]  cas_half_o;
    logic [3:0]  ras_cyc_o;
    logic        lat_ok_o;
    logic [15:0] wr_seen;
    logic [15:0] rd_seen;
    int          bad_count       = 0;
    int          samples_checked = 0;
    // valid maps and their geometry {ok,bus32,lp,bank4,row,col}
    localparam logic [7:0]  MAPS[5] = '{8'h00, 8'h0D, 8'h30, 8'h86, 8'hAA};
    localparam logic [11:0] GEOS[5] = '{12'h8B9, 12'h9D9, 12'hBDB,
                                        12'hDB8, 12'hFC8};
    localparam logic [7:0]  BADS[3] = '{8'h06, 8'h40, 8'h12};

    always #2 sys_clk_i = ~sys_clk_i;

    sdcs_top dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .req_vld_i(req_vld_i),
        .req_wr_i(req_wr_i), .req_addr_i(req_addr_i), .cmd_o(cmd_o),
        .wp_block_o(wp_block_o), .geo_o(geo_o), .wp_o(wp_o), .md_o(md_o),
        .md_ok_o(md_ok_o), .cas_half_o(cas_half_o),
        .ras_cyc_o(ras_cyc_o), .lat_ok_o(lat_ok_o)
    );

    sdcs_sdram_model mem (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_o),
        .wr_seen_o(wr_seen), .rd_seen_o(rd_seen)
    );

    task automatic close_out();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata_o);
    endtask

    // one request; returns with the answer cycle settled
    task automatic req(input logic w, input logic [31:0] a);
        @(posedge sys_clk_i);
        req_vld_i  <= 1'b1;
        req_wr_i   <= w;
        req_addr_i <= a;
        @(posedge sys_clk_i);
        req_vld_i  <= 1'b0;
        #1;
    endtask

    function automatic logic [31:0] ones(input int n);
        return (32'h1 << n) - 32'h1;
    endfunction

    // expected {bank,row,col} from geometry alone
    function automatic logic [25:0] xl(input logic [11:0] g,
                                       input logic [31:0] a);
        logic [31:0] w;
        logic [31:0] bank;
        logic [31:0] row;
        logic [31:0] col;
        int          cl;
        int          rl;
        int          bb;
        w   = g[10] ? (a >> 2) : (a >> 1);
        cl  = int'(g[3:0]);
        rl  = int'(g[7:4]);
        bb  = g[8] ? 2 : 1;
        col = w & ones(cl);
        if (g[9]) begin
            row  = (w >> cl) & ones(rl);
            bank = (w >> (cl + rl)) & ones(bb);
        end else begin
            bank = (w >> cl) & ones(bb);
            row  = (w >> (cl + bb)) & ones(rl);
        end
        return {bank[1:0], row[12:0], col[10:0]};
    endfunction

    task automatic t_regs();
        reg_wr(SDCS_CFG_ADDR, 32'hFFFF_C37C);
        #1;
        chk("wp early", 32'h0, {31'h0, wp_o});
        settle(1);
        chk("wp", 32'h1, {31'h0, wp_o});
        rd_chk(SDCS_CFG_ADDR, 32'h0010_4304);
        reg_wr(SDCS_LAT_ADDR, 32'hFFFF_FFFF);
        rd_chk(SDCS_LAT_ADDR, 32'h0000_078F);
        reg_wr(32'h3108_0108, 32'hFFFF_FFFF);
        rd_chk(32'h3108_0108, 32'h0);
        rd_chk(SDCS_CFG_ADDR, 32'h0010_4304);
    endtask

    task automatic t_codes();
        for (int i = 0; i < 8; i++) begin
            reg_wr(SDCS_CFG_ADDR, 32'(i));
            settle(2);
            chk("type", 32'(i), {29'h0, md_o});
            chk("type ok", {31'h0, ~i[0]}, {31'h0, md_ok_o});
        end
        for (int k = 0; k < 16; k++) begin
            reg_wr(SDCS_LAT_ADDR, (32'(k) << 7) | 32'(k));
            settle(2);
            chk("cas", 32'(k), {28'h0, cas_half_o});
            chk("ras", 32'(k), {28'h0, ras_cyc_o});
            chk("lat ok", {31'h0, k != 0}, {31'h0, lat_ok_o});
        end
    endtask

    task automatic t_maps();
        logic [31:0] a;
        for (int m = 0; m < 5; m++) begin
            reg_wr(SDCS_CFG_ADDR, 32'(MAPS[m]) << 7);
            settle(3);
            chk("geometry", 32'(GEOS[m]), 32'(geo_o));
            for (int j = 0; j < 3; j++) begin
                a = 32'h0123_4567 ^ (32'h02AA_55AA << j);
                req(1'(j), a);
                chk("cmd vld", 32'h1, {31'h0, cmd_o.vld});
                chk("cmd wr", 32'(j & 1), {31'h0, cmd_o.wr});
                chk("cmd", {6'h0, xl(GEOS[m], a)},
                    {6'h0, cmd_o.bank, cmd_o.row, cmd_o.col});
            end
        end
        for (int b = 0; b < 3; b++) begin
            reg_wr(SDCS_CFG_ADDR, 32'(BADS[b]) << 7);
            settle(3);
            chk("map ok", 32'h0, {31'h0, geo_o.ok});
        end
    endtask

    task automatic t_protect();
        logic [15:0] w0;
        reg_wr(SDCS_CFG_ADDR, 32'h0010_0000);
        settle(2);
        w0 = wr_seen;
        req(1'b1, 32'h0000_1000);
        chk("blocked", 32'h1, {31'h0, wp_block_o});
        chk("no cmd", 32'h0, {31'h0, cmd_o.vld});
        req(1'b0, 32'h0000_1000);
        chk("read passes", 32'h1, {31'h0, cmd_o.vld});
        chk("no block", 32'h0, {31'h0, wp_block_o});
        reg_wr(SDCS_CFG_ADDR, 32'h0);
        settle(2);
        req(1'b1, 32'h0000_1000);
        chk("write passes", 32'h1, {31'h0, cmd_o.vld & cmd_o.wr});
        settle(1);
        chk("pulse ends", 32'h0, {31'h0, cmd_o.vld});
        chk("writes seen", 32'(w0) + 32'h1, 32'(wr_seen));
    endtask

    initial begin
        #20000;
        bad_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        settle(1);
        rd_chk(SDCS_CFG_ADDR, 32'h0);
        rd_chk(SDCS_LAT_ADDR, 32'h0000_0303);
        chk("reset geometry", 32'h8B9, 32'(geo_o));
        t_regs(); // set up before any request is made
        t_codes(); // every type code and every latency code 0..15, legal or not
        t_maps(); // bus width from the map's own bit, x8 devices also on a 16-bit bus
        t_protect();
        close_out();
    end
endmodule
